// ---- sbgp_pkg.sv ----
`timescale 1ns/1ps
package sbgp_pkg;

    // Port geometry
    localparam int PIN_COUNT = 6;
    localparam int REG_WIDTH = 8;
    localparam int DATA_WIDTH = 32;
    localparam int ADDR_WIDTH = 8;
    localparam int STRB_WIDTH = DATA_WIDTH / 8;

    // Byte addresses of the register words
    localparam logic [ADDR_WIDTH-1:0] OFS_DIRECTION = 8'h00;
    localparam logic [ADDR_WIDTH-1:0] OFS_OUT_LATCH = 8'h04;
    localparam logic [ADDR_WIDTH-1:0] OFS_LEVEL = 8'h08;
    localparam logic [ADDR_WIDTH-1:0] OFS_OPEN_DRAIN = 8'h0C;
    localparam logic [ADDR_WIDTH-1:0] OFS_ALT_SELECT = 8'h10;

    // Word select uses the address above the byte lanes
    localparam int WORD_LSB = 2;

    // Reset values of the writable registers
    localparam logic [PIN_COUNT-1:0] RST_DIRECTION = 6'h00;
    localparam logic [PIN_COUNT-1:0] RST_OUT_LATCH = 6'h00;
    localparam logic [PIN_COUNT-1:0] RST_OPEN_DRAIN = 6'h00;
    localparam logic [PIN_COUNT-1:0] RST_ALT_SELECT = 6'h00;

    // Level of an idle pin output and of a released enable
    localparam logic [PIN_COUNT-1:0] PINS_LOW = 6'h00;
    localparam logic [PIN_COUNT-1:0] PINS_RELEASED = 6'h3F;

    // Value returned for a word with nothing readable in it
    localparam logic [DATA_WIDTH-1:0] READ_ZERO = 32'h0000_0000;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// Two-stage synchroniser for levels arriving from the board
module sbgp_sync #(
    parameter int WIDTH = sbgp_pkg::PIN_COUNT
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Asynchronous level in, clean level out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import sbgp_pkg::*;

    // First stage feeds only the second stage
    logic [WIDTH-1:0] meta;

    // No reset here: stages keep tracking the pins through reset
    // So the pin-state view shows real levels as soon as reset ends
    wire unused_rst = aresetn;

    // Both stages sample on every rising edge
    always_ff @(posedge aclk)
    begin
        meta <= async_in;
        sync_out <= meta;
    end

endmodule // sbgp_sync

// ---- sbgp_port.sv ----
`timescale 1ns/1ps

// Behaviour
// - Six pins on bits five to zero
// - Bits seven, six read zero, writes ignored
// - Direction register write-only, read unspecified
// - Direction one drives output, zero input, reset
// - Output latch read-write, drives outputs, resets zero
// - Pin-state register read-only, writes ignored
// - Readback: latch if output, pin if input
// - Readback follows live pins right after reset
// - Open-drain bit drives low only, resets zero
module sbgp_port (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [sbgp_pkg::ADDR_WIDTH-1:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [sbgp_pkg::DATA_WIDTH-1:0] wdata,
    input wire logic [sbgp_pkg::STRB_WIDTH-1:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [sbgp_pkg::ADDR_WIDTH-1:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [sbgp_pkg::DATA_WIDTH-1:0] rdata,
    output logic [1:0] rresp,
    // Alternate peripheral drive, same clock domain
    input wire logic [sbgp_pkg::PIN_COUNT-1:0] alt_out,
    input wire logic [sbgp_pkg::PIN_COUNT-1:0] alt_drive,
    // Board pins, split into level, value and enable
    input wire logic [sbgp_pkg::PIN_COUNT-1:0] pin_in,
    output logic [sbgp_pkg::PIN_COUNT-1:0] pin_out,
    output logic [sbgp_pkg::PIN_COUNT-1:0] pin_oe_n
);
    import sbgp_pkg::*;

    // Widen a pin field into a bus word, upper bits forced to zero
    function automatic logic [DATA_WIDTH-1:0] pin_word(input logic [PIN_COUNT-1:0] f);
        pin_word = {{(DATA_WIDTH-PIN_COUNT){1'b0}}, f};
    endfunction

    // Word index of a byte address, byte lanes dropped
    function automatic logic [ADDR_WIDTH-1:0] word_of(input logic [ADDR_WIDTH-1:0] a);
        word_of = {{WORD_LSB{1'b0}}, a[ADDR_WIDTH-1:WORD_LSB]};
    endfunction

    // Software-visible control state
    logic [PIN_COUNT-1:0] pin_direction_control; // One bit per pin, 1 = output
    logic [PIN_COUNT-1:0] output_data_latch; // Value for general-purpose outputs
    logic [PIN_COUNT-1:0] open_drain_select; // 1 = drive low only
    logic [PIN_COUNT-1:0] alt_select; // 1 = pin handed to a peripheral

    // Synchronised pin levels
    logic [PIN_COUNT-1:0] pin_sync;

    // Write channel holding registers
    logic aw_held;
    logic [ADDR_WIDTH-1:0] aw_addr;
    logic w_held;
    logic [DATA_WIDTH-1:0] w_data;
    logic [STRB_WIDTH-1:0] w_strb;

    // Next values of the pin drivers
    logic [PIN_COUNT-1:0] next_pin_out;
    logic [PIN_COUNT-1:0] next_pin_oe_n;

    // Pins pass two flops before any logic looks at them
    sbgp_sync #(
        .WIDTH(PIN_COUNT)
    ) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // Handshake decode
    wire aw_take = awvalid && awready;
    wire w_take = wvalid && wready;
    wire ar_take = arvalid && arready;
    wire do_write = aw_held && w_held && !bvalid;
    // Only the low byte lane carries register bits
    wire low_lane = w_strb[0];

    // Write target decode
    wire [ADDR_WIDTH-1:0] w_word = word_of(aw_addr);
    wire wr_direction = (w_word == word_of(OFS_DIRECTION));
    wire wr_latch = (w_word == word_of(OFS_OUT_LATCH));
    wire wr_level = (w_word == word_of(OFS_LEVEL));
    wire wr_open_drain = (w_word == word_of(OFS_OPEN_DRAIN));
    wire wr_alt = (w_word == word_of(OFS_ALT_SELECT));
    wire wr_mapped = wr_direction || wr_latch || wr_level || wr_open_drain || wr_alt;

    // Read target decode
    wire [ADDR_WIDTH-1:0] r_word = word_of(araddr);
    wire rd_direction = (r_word == word_of(OFS_DIRECTION));
    wire rd_latch = (r_word == word_of(OFS_OUT_LATCH));
    wire rd_level = (r_word == word_of(OFS_LEVEL));
    wire rd_open_drain = (r_word == word_of(OFS_OPEN_DRAIN));
    wire rd_alt = (r_word == word_of(OFS_ALT_SELECT));
    wire rd_mapped = rd_direction || rd_latch || rd_level || rd_open_drain || rd_alt;

    // Pin-state view: latch for outputs, live level for inputs
    wire [PIN_COUNT-1:0] level_view =
        (pin_direction_control & output_data_latch) |
        (~pin_direction_control & pin_sync);

    // Read data mux; direction register is write-only and reads zero
    wire [DATA_WIDTH-1:0] read_mux =
        rd_direction ? READ_ZERO :
        rd_latch ? pin_word(output_data_latch) :
        rd_level ? pin_word(level_view) :
        rd_open_drain ? pin_word(open_drain_select) :
        rd_alt ? pin_word(alt_select) :
        READ_ZERO;

    // Channel readies: one write and one read in flight at a time
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign arready = !rvalid;

    // Per-pin drive: peripheral first, then general-purpose output
    always_comb
    begin
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            if (alt_select[i])
            begin
                // Peripheral owns value and enable
                next_pin_out[i] = alt_out[i];
                next_pin_oe_n[i] = !alt_drive[i];
            end
            else if (pin_direction_control[i])
            begin
                // Open drain only pulls low; a high is a released pin
                next_pin_out[i] = output_data_latch[i];
                next_pin_oe_n[i] = open_drain_select[i] && output_data_latch[i];
            end
            else
            begin
                // Input: never drive
                next_pin_out[i] = 1'b0;
                next_pin_oe_n[i] = 1'b1;
            end
        end
    end

    // Pin driver flops; all pins released during reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_out <= PINS_LOW;
            pin_oe_n <= PINS_RELEASED;
        end
        else
        begin
            pin_out <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
        end
    end

    // Address half of a write, held until the write is done
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end
        else if (aw_take)
        begin
            aw_held <= 1'b1;
            aw_addr <= awaddr;
        end
        else if (do_write)
        begin
            aw_held <= 1'b0;
        end
    end

    // Data half of a write, may arrive before or after the address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end
        else if (w_take)
        begin
            w_held <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
        end
        else if (do_write)
        begin
            w_held <= 1'b0;
        end
    end

    // Direction register; bits above the pins are never stored
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_direction_control <= RST_DIRECTION;
        end
        else if (do_write && wr_direction && low_lane)
        begin
            pin_direction_control <= w_data[PIN_COUNT-1:0];
        end
    end

    // Output data latch
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            output_data_latch <= RST_OUT_LATCH;
        end
        else if (do_write && wr_latch && low_lane)
        begin
            output_data_latch <= w_data[PIN_COUNT-1:0];
        end
    end

    // Open-drain select
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            open_drain_select <= RST_OPEN_DRAIN;
        end
        else if (do_write && wr_open_drain && low_lane)
        begin
            open_drain_select <= w_data[PIN_COUNT-1:0];
        end
    end

    // Alternate-function select
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            alt_select <= RST_ALT_SELECT;
        end
        else if (do_write && wr_alt && low_lane)
        begin
            alt_select <= w_data[PIN_COUNT-1:0];
        end
    end

    // Write response; pin-state word takes the write and drops it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else if (do_write)
        begin
            // Pin-state writes answer OKAY but store nothing
            bvalid <= 1'b1;
            bresp <= wr_mapped ? RESP_OKAY : RESP_DECERR;
        end
        else if (bvalid && bready)
        begin
            bvalid <= 1'b0;
        end
    end

    // Read response; data captured at the address handshake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata <= READ_ZERO;
            rresp <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            // Pin level is sampled now, so a slow master sees a snapshot
            rvalid <= 1'b1;
            rdata <= read_mux;
            rresp <= rd_mapped ? RESP_OKAY : RESP_DECERR;
        end
        else if (rvalid && rready)
        begin
            rvalid <= 1'b0;
        end
    end

    // Protection bits carry no meaning for this port
    wire unused_prot = ^{awprot, arprot, w_data[DATA_WIDTH-1:PIN_COUNT], w_strb};

endmodule // sbgp_port

// ---- sbgp_board.sv ----
`timescale 1ns/1ps
// Board side of the six pins, pulled up where nobody drives
module sbgp_board (
    // Device drive
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe_n,
    // Board drive per pin
    input wire logic [5:0] ext_val,
    input wire logic [5:0] ext_en,
    // Resolved wire level
    output logic [5:0] pin_level
);
    // Device wins where it drives; a released open-drain high floats up
    assign pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & (ext_val | ~ext_en));
endmodule // sbgp_board

// ---- sbgp_port_sva.sv ----
`timescale 1ns/1ps
// Watches the port block from its ports only
module sbgp_chk
    import sbgp_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [7:0] araddr,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    // Peripheral and pins
    input wire logic [5:0] alt_out,
    input wire logic [5:0] alt_drive,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe_n
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Reset itself is the cause here, so it must not disable this one
    AST_RST_RELEASE: assert property (disable iff (1'b0) !aresetn |=>
        pin_oe_n == PINS_RELEASED && !bvalid && !rvalid) else $error("pins not released");
    AST_RD_HIGH_ZERO: assert property (rvalid |-> rdata[31:6] == 26'h0)
        else $error("upper read bits set");
    AST_RD_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    AST_AR_ANSWER: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read not answered in one cycle");
    AST_UNMAPPED: assert property (arvalid && arready && araddr[7:2] > 6'h04 |=>
        rresp == RESP_DECERR) else $error("unmapped read not refused");
    AST_WR_ANSWER: assert property (awvalid && awready && wvalid && wready |=>
        !bvalid ##1 bvalid) else $error("write answer late");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer not held");
    AST_B_DONE: assert property (bvalid && bready |=> !bvalid)
        else $error("write answer not withdrawn");
    AST_R_DONE: assert property (rvalid && rready |=> !rvalid)
        else $error("read answer not withdrawn");
    // Pins move only after a register write or a peripheral change
    AST_PIN_CAUSE: assert property ($changed({pin_out, pin_oe_n}) |-> $past(bvalid)
        || $past(alt_out) != $past(alt_out, 2) || $past(alt_drive) != $past(alt_drive, 2))
        else $error("pins moved without cause");
endmodule // sbgp_chk

bind sbgp_port sbgp_chk i_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .alt_out, .alt_drive, .pin_out, .pin_oe_n);

// ---- tb.sv ----
`timescale 1ns/1ps
// Register-level bench for the six-pin port
module tb;
    import sbgp_pkg::*;
    // Design inputs and board drive
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [5:0] alt_out, alt_drive, ext_val, ext_en;
    // Design outputs and wire level
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [5:0] pin_level, pin_out, pin_oe_n;
    int errors = 0;
    int comparisons = 0;
    sbgp_port i_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .alt_out,
        .alt_drive, .pin_in(pin_level), .pin_out, .pin_oe_n);
    sbgp_board i_board (.pin_out, .pin_oe_n, .ext_val, .ext_en, .pin_level);
    // 250 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // A wait that ran out ends the run
    task automatic hang(input int n);
        if (n >= 50)
        begin
            errors++;
            finish_test();
        end
    endtask
    // Write; bready stands from the request until the answer is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
        hang(n);
    endtask
    // Read; data compared only when a normal answer is expected
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        chk(32'(rresp), 32'(er));
        if (er == RESP_OKAY) chk(rdata, e);
        hang(n);
    endtask
    task automatic tend(input int t);
        $display("test %0d done", t);
    endtask
    // Main sequence
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = 48'h0;
        {alt_out, alt_drive} = 12'h000;
        ext_val = 6'h2A;
        ext_en = 6'h3C;
        wstrb = 4'hF;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(32'(pin_oe_n), 32'h3F);
        rd(OFS_OUT_LATCH, 32'h00, RESP_OKAY);
        rd(OFS_LEVEL, 32'h2B, RESP_OKAY);
        rd(OFS_OPEN_DRAIN, 32'h00, RESP_OKAY);
        rd(OFS_ALT_SELECT, 32'h00, RESP_OKAY);
        tend(1);
        wr(OFS_OUT_LATCH, 32'hFFFF_FFD5, RESP_OKAY);
        rd(OFS_OUT_LATCH, 32'h15, RESP_OKAY);
        // Low byte lane off: the write is answered but stores nothing
        wstrb <= 4'hE;
        wr(OFS_OUT_LATCH, 32'h3F, RESP_OKAY);
        wstrb <= 4'hF;
        rd(OFS_OUT_LATCH, 32'h15, RESP_OKAY);
        wr(OFS_DIRECTION, 32'hCF, RESP_OKAY);
        // Pins move on the answer edge, so look one edge later
        @(posedge aclk);
        chk(32'(pin_oe_n), 32'h30);
        chk(32'(pin_out & 6'h0F), 32'h05);
        rd(OFS_LEVEL, 32'h25, RESP_OKAY);
        ext_val <= 6'h15;
        repeat (3) @(posedge aclk);
        rd(OFS_LEVEL, 32'h15, RESP_OKAY);
        wr(OFS_LEVEL, 32'h3F, RESP_OKAY);
        rd(OFS_LEVEL, 32'h15, RESP_OKAY);
        tend(2);
        wr(OFS_OPEN_DRAIN, 32'hFF, RESP_OKAY);
        rd(OFS_OPEN_DRAIN, 32'h3F, RESP_OKAY);
        chk(32'(pin_oe_n), 32'h35);
        rd(OFS_LEVEL, 32'h15, RESP_OKAY);
        tend(3);
        wr(OFS_OPEN_DRAIN, 32'h00, RESP_OKAY);
        alt_out <= 6'h02;
        alt_drive <= 6'h01;
        wr(OFS_ALT_SELECT, 32'h03, RESP_OKAY);
        wr(OFS_OUT_LATCH, 32'h00, RESP_OKAY);
        @(posedge aclk);
        chk(32'(pin_oe_n), 32'h32);
        chk(32'(pin_out & 6'h0F), 32'h02);
        alt_drive <= 6'h02;
        repeat (2) @(posedge aclk);
        chk(32'(pin_oe_n), 32'h31);
        tend(4);
        wr(8'h20, 32'h3F, RESP_DECERR);
        rd(8'h20, 32'h00, RESP_DECERR);
        tend(5);
        // Three edges, so no pin-change attempt straddles the release
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // Earliest legal read must already show the live pin levels
        rd(OFS_LEVEL, 32'h17, RESP_OKAY);
        chk(32'(pin_oe_n), 32'h3F);
        rd(OFS_OUT_LATCH, 32'h00, RESP_OKAY);
        rd(OFS_ALT_SELECT, 32'h00, RESP_OKAY);
        tend(6);
        finish_test();
    end
endmodule // tb
